// ==== inc/tm8w_defs.svh ====
// Offsets, field positions, reset values and timing counts of the 8-bit waveform timer
`ifndef TM8W_DEFS_SVH
`define TM8W_DEFS_SVH

// ==========================================================
// Register byte addresses
`define TM8W_ADR_CTRL 8'h00
`define TM8W_ADR_CMPA 8'h04
`define TM8W_ADR_CMPB 8'h08
`define TM8W_ADR_COUNT 8'h0c
`define TM8W_ADR_STAT 8'h10

// ==========================================================
// Control register fields
`define TM8W_CTRL_MODE_LSB 0
`define TM8W_CTRL_MODE_MSB 2
`define TM8W_CTRL_ACTA_LSB 4
`define TM8W_CTRL_ACTA_MSB 5
`define TM8W_CTRL_ACTB_LSB 6
`define TM8W_CTRL_ACTB_MSB 7
`define TM8W_CTRL_CSEL_LSB 8
`define TM8W_CTRL_CSEL_MSB 10
`define TM8W_CTRL_DIRA 12
`define TM8W_CTRL_DIRB 13

// ==========================================================
// Status register fields
`define TM8W_STAT_OVF 0
`define TM8W_STAT_CMPA 1
`define TM8W_STAT_CMPB 2
`define TM8W_STAT_DOWN 8

// ==========================================================
// Values
`define TM8W_BOTTOM 8'h00
`define TM8W_MAX 8'hff
`define TM8W_RST_BYTE 8'h00
`define TM8W_ACT_TOGGLE 2'h1
`define TM8W_ACT_NONINV 2'h2
`define TM8W_ACT_INV 2'h3

// ==========================================================
// Prescaler selections and divider masks
`define TM8W_CSEL_DIV1 3'h1
`define TM8W_CSEL_DIV8 3'h2
`define TM8W_CSEL_DIV64 3'h3
`define TM8W_CSEL_DIV256 3'h4
`define TM8W_CSEL_DIV1024 3'h5
`define TM8W_MASK_DIV8 10'h007
`define TM8W_MASK_DIV64 10'h03f
`define TM8W_MASK_DIV256 10'h0ff
`define TM8W_MASK_DIV1024 10'h3ff

`endif

// ==== inc/tm8w_pkg.sv ====
// Types shared by the 8-bit waveform timer
package tm8w_pkg;

  typedef logic [7:0] tm8w_byte_t;

  // Waveform generation modes
  typedef enum logic [2:0] {
    TM8W_NORMAL = 3'h0,
    TM8W_PC_MAX = 3'h1,
    TM8W_CLR_CMP = 3'h2,
    TM8W_FAST_MAX = 3'h3,
    TM8W_PC_CMPA = 3'h5,
    TM8W_FAST_CMPA = 3'h7
  } tm8w_mode_e;

  // Counting direction, one-hot
  typedef enum logic [1:0] {
    TM8W_UP = 2'b01,
    TM8W_DOWN = 2'b10
  } tm8w_dir_e;

endpackage

// ==== rtl/tm8w_presc.sv ====
// Prescaler that turns the system clock into a one-cycle timer tick
`timescale 1ns/1ps
module tm8w_presc
  import tm8w_pkg::*;
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic [2:0] csel_i,
  output logic tick_o
);

`include "tm8w_defs.svh"

  logic [9:0] div_cnt;
  logic next_tick;

  // ==========================================================
  // Free running divider
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      div_cnt <= 10'h000;
    else
      div_cnt <= div_cnt + 10'h001;
  end

  // ==========================================================
  // Tick selection
  always_comb
  begin
    case (csel_i)
      `TM8W_CSEL_DIV1: next_tick = 1'b1;
      `TM8W_CSEL_DIV8: next_tick = &(div_cnt | ~`TM8W_MASK_DIV8);
      `TM8W_CSEL_DIV64: next_tick = &(div_cnt | ~`TM8W_MASK_DIV64);
      `TM8W_CSEL_DIV256: next_tick = &(div_cnt | ~`TM8W_MASK_DIV256);
      `TM8W_CSEL_DIV1024: next_tick = &(div_cnt | ~`TM8W_MASK_DIV1024);
      default: next_tick = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      tick_o <= 1'b0;
    else
      tick_o <= next_tick;
  end

endmodule

// ==== rtl/tm8w_top.sv ====
// 8-bit timer with clear-on-compare, fast PWM and phase-correct PWM waveforms
//
// Operation
// - Mode 2 clears count on channel A match
// - Mode 2 compare A unbuffered; missed match wraps
// - Mode 2 raises compare A flag one tick after top
// - Mode 2 action 1 toggles output A
// - Pin shows waveform only when direction outputs
// - Mode 2 overflow flag at max to zero
// - Modes 3/7 fast PWM, top max or A
// - Fast PWM clears count tick after top
// - Fast PWM sets overflow flag at top
// - Fast PWM: match clears, top sets (non-inverting)
// - Action 2 non-inverted, action 3 inverted
// - Fast PWM toggle A only with mode bit2
// - Bottom compare spikes; max compare constant
// - Compare registers double buffered in fast PWM
// - Modes 1/5 dual slope, top max or A
// - Count holds top one tick, then down
// - Phase-correct sets overflow flag at bottom
// - Up match clears, down match sets
// - Phase-correct toggle A only with mode bit2
// - Compare bottom low, max high, inverted opposite
// - Output at top compare takes down-count match level
// - Missed down match corrected at bottom
// - Compare flag set one tick after match
// - PWM modes buffer compare; others write direct
`timescale 1ns/1ps
module tm8w_top
  import tm8w_pkg::*;
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wave_out_a_o,
  output logic wave_out_a_oe_o,
  output logic wave_out_b_o,
  output logic wave_out_b_oe_o
);

`include "tm8w_defs.svh"

  // ==========================================================
  // Declarations
  logic [2:0] waveform_mode_sel;
  logic [1:0] out_a_action;
  logic [1:0] out_b_action;
  logic [2:0] clk_sel;
  logic dir_out_a;
  logic dir_out_b;
  tm8w_byte_t compare_a_value;
  tm8w_byte_t compare_b_value;
  tm8w_byte_t compare_a_buf;
  tm8w_byte_t compare_b_buf;
  tm8w_byte_t count_value;
  tm8w_dir_e cnt_dir;
  logic overflow_flag;
  logic compare_a_flag;
  logic compare_b_flag;
  logic pend_a;
  logic pend_b;
  logic match_block;
  logic wave_a;
  logic wave_b;
  logic tick;
  logic wr_en;
  logic wr_ctrl;
  logic wr_cmpa;
  logic wr_cmpb;
  logic wr_count;
  logic wr_stat;
  logic fast;
  logic dual;
  logic pwm;
  logic clr_cmp;
  logic waveform_mode_bit2;
  tm8w_byte_t top;
  logic at_top;
  logic at_bottom;
  logic match_a;
  logic match_b;
  logic load_buf;
  logic set_ovf;
  logic next_wave_a;
  logic next_wave_b;
  tm8w_byte_t next_count;
  logic [31:0] next_rdata;

  // ==========================================================
  // Decoding helpers
  function automatic logic is_fast(input logic [2:0] m);
    is_fast = (m == TM8W_FAST_MAX) || (m == TM8W_FAST_CMPA);
  endfunction

  function automatic logic is_dual(input logic [2:0] m);
    is_dual = (m == TM8W_PC_MAX) || (m == TM8W_PC_CMPA);
  endfunction

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] reg_adr);
    hit = adr[7:2] == reg_adr[7:2];
  endfunction

  // Next output level of one channel on a timer tick
  function automatic logic wave_step(
    input logic cur,
    input logic [1:0] act,
    input logic may_toggle,
    input logic match,
    input logic cmp_at_top,
    input logic cmp_at_bottom
  );
    wave_step = cur;
    if (act == `TM8W_ACT_TOGGLE)
    begin
      if (match && (!pwm || may_toggle))
        wave_step = ~cur;
    end
    else if (act[1])
    begin
      if (fast)
      begin
        if (at_top)
          wave_step = ~act[0];
        else if (match)
          wave_step = act[0];
      end
      else if (dual)
      begin
        if (at_bottom)
          wave_step = cmp_at_bottom ? act[0] : ~act[0];
        else if (at_top && cnt_dir == TM8W_UP)
          wave_step = cmp_at_top ? ~act[0] : (match ? act[0] : cur);
        else if (match)
          wave_step = (cnt_dir == TM8W_UP) ? act[0] : ~act[0];
      end
      else if (match)
        wave_step = act[0];
    end
  endfunction

  // ==========================================================
  // Mode decode
  assign fast = is_fast(waveform_mode_sel);
  assign dual = is_dual(waveform_mode_sel);
  assign pwm = fast || dual;
  assign clr_cmp = waveform_mode_sel == TM8W_CLR_CMP;
  assign waveform_mode_bit2 = waveform_mode_sel[2];
  assign top = (clr_cmp || (pwm && waveform_mode_bit2)) ? compare_a_value : `TM8W_MAX;
  assign at_top = count_value == top;
  assign at_bottom = dual && count_value == `TM8W_BOTTOM;
  assign match_a = (count_value == compare_a_value) && !match_block;
  assign match_b = (count_value == compare_b_value) && !match_block;
  assign load_buf = tick && ((fast && at_top) || (dual && at_top && cnt_dir == TM8W_UP));

  // ==========================================================
  // Wishbone slave
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign wr_ctrl = wr_en && hit(wb_adr_i, `TM8W_ADR_CTRL);
  assign wr_cmpa = wr_en && hit(wb_adr_i, `TM8W_ADR_CMPA) && wb_sel_i[0];
  assign wr_cmpb = wr_en && hit(wb_adr_i, `TM8W_ADR_CMPB) && wb_sel_i[0];
  assign wr_count = wr_en && hit(wb_adr_i, `TM8W_ADR_COUNT) && wb_sel_i[0];
  assign wr_stat = wr_en && hit(wb_adr_i, `TM8W_ADR_STAT) && wb_sel_i[0];

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
  end

  always_comb
  begin
    next_rdata = 32'h00000000;
    if (hit(wb_adr_i, `TM8W_ADR_CTRL))
    begin
      next_rdata[`TM8W_CTRL_MODE_MSB:`TM8W_CTRL_MODE_LSB] = waveform_mode_sel;
      next_rdata[`TM8W_CTRL_ACTA_MSB:`TM8W_CTRL_ACTA_LSB] = out_a_action;
      next_rdata[`TM8W_CTRL_ACTB_MSB:`TM8W_CTRL_ACTB_LSB] = out_b_action;
      next_rdata[`TM8W_CTRL_CSEL_MSB:`TM8W_CTRL_CSEL_LSB] = clk_sel;
      next_rdata[`TM8W_CTRL_DIRA] = dir_out_a;
      next_rdata[`TM8W_CTRL_DIRB] = dir_out_b;
    end
    else if (hit(wb_adr_i, `TM8W_ADR_CMPA))
      next_rdata[7:0] = compare_a_buf;
    else if (hit(wb_adr_i, `TM8W_ADR_CMPB))
      next_rdata[7:0] = compare_b_buf;
    else if (hit(wb_adr_i, `TM8W_ADR_COUNT))
      next_rdata[7:0] = count_value;
    else if (hit(wb_adr_i, `TM8W_ADR_STAT))
    begin
      next_rdata[`TM8W_STAT_OVF] = overflow_flag;
      next_rdata[`TM8W_STAT_CMPA] = compare_a_flag;
      next_rdata[`TM8W_STAT_CMPB] = compare_b_flag;
      next_rdata[`TM8W_STAT_DOWN] = cnt_dir == TM8W_DOWN;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      wb_dat_o <= 32'h00000000;
    else if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o)
      wb_dat_o <= next_rdata;
  end

  // ==========================================================
  // Control register
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      waveform_mode_sel <= 3'h0;
      out_a_action <= 2'h0;
      out_b_action <= 2'h0;
      clk_sel <= 3'h0;
      dir_out_a <= 1'b0;
      dir_out_b <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      if (wb_sel_i[0])
      begin
        waveform_mode_sel <= wb_dat_i[`TM8W_CTRL_MODE_MSB:`TM8W_CTRL_MODE_LSB];
        out_a_action <= wb_dat_i[`TM8W_CTRL_ACTA_MSB:`TM8W_CTRL_ACTA_LSB];
        out_b_action <= wb_dat_i[`TM8W_CTRL_ACTB_MSB:`TM8W_CTRL_ACTB_LSB];
      end
      if (wb_sel_i[1])
      begin
        clk_sel <= wb_dat_i[`TM8W_CTRL_CSEL_MSB:`TM8W_CTRL_CSEL_LSB];
        dir_out_a <= wb_dat_i[`TM8W_CTRL_DIRA];
        dir_out_b <= wb_dat_i[`TM8W_CTRL_DIRB];
      end
    end
  end

  // ==========================================================
  // Timer tick
  tm8w_presc u_presc (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .csel_i(clk_sel),
    .tick_o(tick)
  );

  // ==========================================================
  // Compare buffers and active compare values
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      compare_a_buf <= `TM8W_RST_BYTE;
      compare_b_buf <= `TM8W_RST_BYTE;
    end
    else
    begin
      if (wr_cmpa)
        compare_a_buf <= wb_dat_i[7:0];
      if (wr_cmpb)
        compare_b_buf <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      compare_a_value <= `TM8W_RST_BYTE;
      compare_b_value <= `TM8W_RST_BYTE;
    end
    else if (!pwm)
    begin
      if (wr_cmpa)
        compare_a_value <= wb_dat_i[7:0];
      if (wr_cmpb)
        compare_b_value <= wb_dat_i[7:0];
    end
    else if (load_buf)
    begin
      compare_a_value <= compare_a_buf;
      compare_b_value <= compare_b_buf;
    end
  end

  // ==========================================================
  // Counter sequencing
  always_comb
  begin
    next_count = count_value + 8'h01;
    set_ovf = count_value == `TM8W_MAX;
    if (clr_cmp && match_a)
      next_count = `TM8W_BOTTOM;
    if (fast)
    begin
      set_ovf = at_top;
      if (at_top)
        next_count = `TM8W_BOTTOM;
    end
    else if (dual)
    begin
      set_ovf = at_bottom && cnt_dir == TM8W_DOWN;
      if (cnt_dir == TM8W_DOWN)
        next_count = at_bottom ? count_value + 8'h01 : count_value - 8'h01;
      else if (at_top)
        next_count = (top == `TM8W_BOTTOM) ? top : count_value - 8'h01;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      count_value <= `TM8W_RST_BYTE;
    else if (wr_count)
      count_value <= wb_dat_i[7:0];
    else if (tick)
      count_value <= next_count;
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      cnt_dir <= TM8W_UP;
    else if (!dual)
      cnt_dir <= TM8W_UP;
    else if (tick)
    begin
      case (cnt_dir)
        TM8W_UP: if (at_top && top != `TM8W_BOTTOM) cnt_dir <= TM8W_DOWN;
        TM8W_DOWN: if (at_bottom) cnt_dir <= TM8W_UP;
        default: cnt_dir <= TM8W_UP;
      endcase
    end
  end

  // A count write blocks matches on the following tick
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      match_block <= 1'b0;
    else if (wr_count)
      match_block <= 1'b1;
    else if (tick)
      match_block <= 1'b0;
  end

  // ==========================================================
  // Flags: a set wins over a write-one clear
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pend_a <= 1'b0;
      pend_b <= 1'b0;
    end
    else if (tick)
    begin
      pend_a <= match_a;
      pend_b <= match_b;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      overflow_flag <= 1'b0;
      compare_a_flag <= 1'b0;
      compare_b_flag <= 1'b0;
    end
    else
    begin
      overflow_flag <= (overflow_flag && !(wr_stat && wb_dat_i[`TM8W_STAT_OVF]))
                       || (tick && set_ovf);
      compare_a_flag <= (compare_a_flag && !(wr_stat && wb_dat_i[`TM8W_STAT_CMPA]))
                        || (tick && pend_a);
      compare_b_flag <= (compare_b_flag && !(wr_stat && wb_dat_i[`TM8W_STAT_CMPB]))
                        || (tick && pend_b);
    end
  end

  // ==========================================================
  // Waveform generation
  always_comb
  begin
    next_wave_a = wave_step(wave_a, out_a_action, waveform_mode_bit2, match_a,
      compare_a_value == top, compare_a_value == `TM8W_BOTTOM);
    next_wave_b = wave_step(wave_b, out_b_action, 1'b0, match_b,
      compare_b_value == top, compare_b_value == `TM8W_BOTTOM);
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wave_a <= 1'b0;
      wave_b <= 1'b0;
    end
    else if (tick)
    begin
      wave_a <= next_wave_a;
      wave_b <= next_wave_b;
    end
  end

  // ==========================================================
  // Pins
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wave_out_a_o <= 1'b0;
      wave_out_a_oe_o <= 1'b0;
      wave_out_b_o <= 1'b0;
      wave_out_b_oe_o <= 1'b0;
    end
    else
    begin
      wave_out_a_o <= dir_out_a && wave_a;
      wave_out_a_oe_o <= dir_out_a;
      wave_out_b_o <= dir_out_b && wave_b;
      wave_out_b_oe_o <= dir_out_b;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i);

  clear_match_a: assert property (tick && clr_cmp && match_a && !wr_count
    |=> count_value == 8'h00)
    else $error("count not cleared on compare match");
  clear_ovf_a: assert property (tick && clr_cmp && count_value == 8'hff |=> overflow_flag)
    else $error("overflow flag missing at wrap");
  clear_toggle_a: assert property (tick && clr_cmp && out_a_action == 2'h1 && match_a
    |=> wave_a != $past(wave_a))
    else $error("output A did not toggle");
  fast_wrap_a: assert property (tick && fast && at_top && !wr_count |=> count_value == 8'h00)
    else $error("fast count not cleared after top");
  fast_set_a: assert property (tick && fast && out_a_action == 2'h2 && at_top |=> wave_a)
    else $error("non-inverted output not set at top");
  dual_hold_a: assert property (tick && dual && cnt_dir == TM8W_UP && at_top
    && top != 8'h00 && !wr_count
    |=> cnt_dir == TM8W_DOWN && count_value == $past(count_value) - 8'h01)
    else $error("top not held for exactly one tick");
  dual_ovf_a: assert property (tick && dual && cnt_dir == TM8W_DOWN && at_bottom
    |=> overflow_flag && cnt_dir == TM8W_UP)
    else $error("overflow flag missing at bottom");
  match_pend_a: assert property (tick && match_a |=> pend_a)
    else $error("match not recorded for the flag");
  flag_late_a: assert property (tick && pend_a |=> compare_a_flag)
    else $error("compare A flag not set one tick after match");
  pwm_buffer_a: assert property (pwm && !load_buf |=> compare_a_value == $past(compare_a_value))
    else $error("compare value changed outside reload");
  pin_gate_a: assert property (!dir_out_a |=> !wave_out_a_oe_o && !wave_out_a_o)
    else $error("waveform visible on input pin");

endmodule

// ==== verif/tm8w_pin_model.sv ====
// Port pin model for one compare waveform output
`timescale 1ns/1ps
module tm8w_pin_model
(
  input wire logic mclk_i,
  input wire logic data_i,
  input wire logic oe_i,
  output logic pin_o
);
  // ==========================================================
  // Pad level
  logic last;

  always_ff @(posedge mclk_i)
  begin
    if (oe_i)
      last <= data_i;
  end

  // Undriven pad floats: show the inverse of the last driven level
  assign pin_o = oe_i ? data_i : ~last;
endmodule

// ==== verif/timer8_waveform_modes_tb.sv ====
// Self-checking bench of the 8-bit waveform timer
`timescale 1ns/1ps
`include "tm8w_defs.svh"
module timer8_waveform_modes_tb;
  import tm8w_pkg::*;
  // ==========================================================
  // Signals
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic wave_out_a_o;
  logic wave_out_a_oe_o;
  logic wave_out_b_o;
  logic wave_out_b_oe_o;
  logic pin_a;
  logic pin_b;
  logic [31:0] q;
  logic [31:0] seed = 32'h00000042;
  int mismatches = 0;
  int checks = 0;
  int ca;
  int cb;
  int n;
  int ha;
  int hb;
  int v;

  always #10 mclk_i = ~mclk_i;

  tm8w_top uut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wave_out_a_o(wave_out_a_o), .wave_out_a_oe_o(wave_out_a_oe_o),
    .wave_out_b_o(wave_out_b_o), .wave_out_b_oe_o(wave_out_b_oe_o));
  tm8w_pin_model pad_a (.mclk_i(mclk_i), .data_i(wave_out_a_o), .oe_i(wave_out_a_oe_o),
    .pin_o(pin_a));
  tm8w_pin_model pad_b (.mclk_i(mclk_i), .data_i(wave_out_b_o), .oe_i(wave_out_b_oe_o),
    .pin_o(pin_b));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] ctrl(input logic [2:0] m, input logic [1:0] aa,
    input logic [1:0] ab, input logic da, input logic db);
    return {18'h0, db, da, 1'b0, `TM8W_CSEL_DIV1, ab, aa, 1'b0, m};
  endfunction

  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    do
    begin
      @(posedge mclk_i);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 50);
    q = wb_dat_o;
    check("bus ack", 32'h1, {31'h0, wb_ack_o});
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic measure(input int span);
    ha = 0;
    hb = 0;
    repeat (span)
    begin
      @(posedge mclk_i);
      if (pin_a === 1'b1)
        ha++;
      if (pin_b === 1'b1)
        hb++;
    end
  endtask

  // ==========================================================
  // Scenarios
  initial
  begin
    repeat (20) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    xfer(1'b0, `TM8W_ADR_CTRL, 32'h0);
    check("ctrl reset", 32'h0, q);
    xfer(1'b0, `TM8W_ADR_STAT, 32'h0);
    check("stat reset", 32'h0, q);
    xfer(1'b0, 8'h14, 32'h0);
    check("unmapped read", 32'h0, q);
    // Fast PWM, A non-inverted, B inverted, extremes first
    for (int i = 0; i < 4; i++)
    begin
      ca = (i == 0) ? 0 : (i == 1) ? 255 : int'(rnd() & 32'hff);
      cb = (i == 0) ? 255 : (i == 1) ? 0 : int'(rnd() & 32'hff);
      xfer(1'b1, `TM8W_ADR_CMPA, ca);
      xfer(1'b1, `TM8W_ADR_CMPB, cb);
      xfer(1'b1, `TM8W_ADR_CTRL, ctrl(TM8W_FAST_MAX, 2'h2, 2'h3, 1'b1, 1'b1));
      repeat (700) @(posedge mclk_i);
      measure(256);
      check("fast high a", ca + 1, ha);
      check("fast high b", 255 - cb, hb);
    end
    xfer(1'b0, `TM8W_ADR_STAT, 32'h0);
    check("fast overflow", 32'h1, q & 32'h1);
    xfer(1'b0, `TM8W_ADR_CMPA, 32'h0);
    check("cmpa readback", ca, q);
    // Phase-correct PWM
    for (int i = 0; i < 4; i++)
    begin
      ca = (i == 0) ? 0 : (i == 1) ? 255 : int'(rnd() & 32'hff);
      cb = (i == 0) ? 255 : (i == 1) ? 0 : int'(rnd() & 32'hff);
      xfer(1'b1, `TM8W_ADR_CMPA, ca);
      xfer(1'b1, `TM8W_ADR_CMPB, cb);
      xfer(1'b1, `TM8W_ADR_CTRL, ctrl(TM8W_PC_MAX, 2'h2, 2'h3, 1'b1, 1'b1));
      repeat (1100) @(posedge mclk_i);
      xfer(1'b1, `TM8W_ADR_STAT, 32'h7);
      measure(510);
      check("dual high a", 2 * ca, ha);
      check("dual high b", 510 - 2 * cb, hb);
      xfer(1'b0, `TM8W_ADR_STAT, 32'h0);
      check("dual overflow", 32'h1, q & 32'h1);
    end
    // Toggle on channel A: clear-on-compare, fast PWM and dual slope with top from A
    for (int m = 0; m < 3; m++)
    begin
      for (int j = 0; j < 3; j++)
      begin
        n = (j == 0) ? 0 : int'(rnd() & 32'hf);
        xfer(1'b1, `TM8W_ADR_CTRL, ctrl((m == 0) ? TM8W_CLR_CMP : (m == 1) ? TM8W_FAST_CMPA
          : TM8W_PC_CMPA, 2'h1, 2'h0, 1'b1, 1'b0));
        xfer(1'b1, `TM8W_ADR_CMPA, n);
        repeat (700) @(posedge mclk_i);
        xfer(1'b1, `TM8W_ADR_STAT, 32'h7);
        v = (m < 2) ? 16 * (n + 1) : (n == 0) ? 16 : 16 * n;
        measure(v);
        check("toggle high a", v / 2, ha);
        xfer(1'b0, `TM8W_ADR_STAT, 32'h0);
        check("compare a flag", 32'h2, q & 32'h2);
      end
    end
    // Clear-on-compare with compare below count: no match before the wrap
    xfer(1'b1, `TM8W_ADR_CTRL, ctrl(TM8W_CLR_CMP, 2'h0, 2'h0, 1'b0, 1'b0));
    xfer(1'b1, `TM8W_ADR_CMPA, 32'h10);
    xfer(1'b1, `TM8W_ADR_COUNT, 32'h20);
    xfer(1'b1, `TM8W_ADR_STAT, 32'h7);
    repeat (100) @(posedge mclk_i);
    xfer(1'b0, `TM8W_ADR_STAT, 32'h0);
    check("no early match", 32'h0, q & 32'h3);
    repeat (200) @(posedge mclk_i);
    xfer(1'b0, `TM8W_ADR_STAT, 32'h0);
    check("wrap flags", 32'h3, q & 32'h3);
    // Stopped timer: flags clear on a write of ones
    xfer(1'b1, `TM8W_ADR_CTRL, 32'h0);
    xfer(1'b1, `TM8W_ADR_STAT, 32'h7);
    xfer(1'b0, `TM8W_ADR_STAT, 32'h0);
    check("flags cleared", 32'h0, q & 32'h7);
    // Direction input: pin logic stays quiet
    xfer(1'b1, `TM8W_ADR_CMPA, 32'h80);
    xfer(1'b1, `TM8W_ADR_CTRL, ctrl(TM8W_FAST_MAX, 2'h2, 2'h2, 1'b0, 1'b0));
    v = 0;
    repeat (600)
    begin
      @(posedge mclk_i);
      if (wave_out_a_o !== 1'b0 || wave_out_a_oe_o !== 1'b0 || wave_out_b_o !== 1'b0
        || wave_out_b_oe_o !== 1'b0)
        v++;
    end
    check("pins undriven", 32'h0, v);
    report_and_stop();
  end

  // ==========================================================
  // Watchdog
  initial
  begin
    repeat (60000) @(posedge mclk_i);
    mismatches++;
    report_and_stop();
  end
endmodule
